// ==== rtl/cwff_regs.vh ====
`ifndef CWFF_REGS_VH
`define CWFF_REGS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define CWFF_IDX_WAKE_CFG   6'h18
`define CWFF_IDX_EXT_MASK   6'h19
`define CWFF_IDX_STD_MASK   6'h1a
`define CWFF_IDX_DATA_1_3   6'h1b
`define CWFF_IDX_DATA_4_6   6'h1c
`define CWFF_IDX_DATA_7_8   6'h1d
`define CWFF_IDX_EXT_REF    6'h30
`define CWFF_IDX_IRQ_STAT   6'h31
`define CWFF_IDX_IRQ_MASK   6'h32

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CWFF_CFG_ID_LSB     0
`define CWFF_CFG_ID_MSB     10
`define CWFF_CFG_DLC_LSB    12
`define CWFF_CFG_DLC_MSB    15
`define CWFF_CFG_IDE_BIT    22
`define CWFF_ST_WAKE        0
`define CWFF_ST_MISS        1

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define CWFF_RST_WORD       24'h000000
`define CWFF_RST_STD_MASK   11'h000
`define CWFF_RST_EXT_MASK   18'h00000
`define CWFF_RST_BYTE       8'h00
`define CWFF_RST_DLC        4'h0
`define CWFF_RST_IRQ        2'h0
`define CWFF_MAX_BYTES      4'h8

`endif

// ==== rtl/cwff_match.v ====
`timescale 1ns/10ps
`include "cwff_regs.vh"

// ----------------------------------------------------------------
// combinational wake-frame comparator
// ----------------------------------------------------------------
module cwff_match (
  // configuration
  input  wire        i_long_format_select,
  input  wire [10:0] i_reference_identifier,
  input  wire [17:0] i_reference_extension,
  input  wire [10:0] i_base_ignore_bits,
  input  wire [17:0] i_extension_ignore_bits,
  input  wire [3:0]  i_match_byte_count,
  input  wire [63:0] i_ref_bytes,
  // received frame
  input  wire        i_frame_ide,
  input  wire [28:0] i_frame_id,
  input  wire [3:0]  i_frame_dlc,
  input  wire [63:0] i_frame_data,
  // result
  output wire        o_hit
);

  wire [28:0] full_ref;
  wire [28:0] full_ign;
  wire [28:0] id_diff;
  wire [3:0]  used_bytes;
  wire [7:0]  byte_ok;
  wire        id_ok;

  // base part is the upper 11 bits, extension the lower 18
  assign full_ref = {i_reference_identifier,
                     i_reference_extension};
  assign full_ign = {i_base_ignore_bits,
                     i_extension_ignore_bits};
  // a set ignore bit drops that bit from the compare
  assign id_diff  = (full_ref ^ i_frame_id) & ~full_ign;

  // standard mode looks only at the base part of the identifier
  assign id_ok = i_long_format_select ?
                 (i_frame_ide & (id_diff == 29'h0)) :
                 (~i_frame_ide & (id_diff[28:18] == 11'h0));

  assign used_bytes = (i_match_byte_count > `CWFF_MAX_BYTES) ?
                      `CWFF_MAX_BYTES : i_match_byte_count;

  genvar k;
  generate
    for (k = 0; k < 8; k = k + 1) begin : g_byte
      assign byte_ok[k] = (used_bytes <= k) ||
        (i_ref_bytes[8*k+7:8*k] == i_frame_data[8*k+7:8*k]);
    end
  endgenerate

  assign o_hit = id_ok & (i_frame_dlc == i_match_byte_count) & (&byte_ok);

endmodule

// ==== rtl/cwff_top.v ====
// The APB register port was decided locally.
`timescale 1ns/10ps
`include "cwff_regs.vh"

module cwff_top (
  // clock and reset
  input  wire        i_clk,
  input  wire        i_sys_rst,
  // apb slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  input  wire [3:0]  i_pstrb,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  // received frame from the bus receiver
  input  wire        i_frame_valid,
  input  wire        i_frame_ide,
  input  wire [28:0] i_frame_id,
  input  wire [3:0]  i_frame_dlc,
  input  wire [63:0] i_frame_data,
  // events
  output reg         o_wake_frame_event,
  output reg         o_irq
);

  // ----------------------------------------------------------------
  // configuration state
  // ----------------------------------------------------------------
  reg  [10:0] base_ignore_bits;
  reg  [17:0] extension_ignore_bits;
  reg  [10:0] reference_identifier;
  reg  [17:0] reference_extension;
  reg  [3:0]  match_byte_count;
  reg         long_format_select;
  reg  [7:0]  ref_byte_one;
  reg  [7:0]  ref_byte_two;
  reg  [7:0]  ref_byte_three;
  reg  [7:0]  ref_byte_four;
  reg  [7:0]  ref_byte_five;
  reg  [7:0]  ref_byte_six;
  reg  [7:0]  ref_byte_seven;
  reg  [7:0]  ref_byte_eight;
  reg  [1:0]  irq_status;
  reg  [1:0]  irq_mask;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire [5:0]  idx;
  wire        aligned;
  wire        setup;
  wire        access;
  wire        wr_ok;
  wire [23:0] next_word;
  wire [1:0]  set_evt;
  wire [1:0]  clr_evt;
  wire [1:0]  next_status;
  wire [1:0]  next_mask;
  wire [63:0] ref_bytes;
  wire        hit;

  assign idx     = i_paddr[7:2];
  assign aligned = (i_paddr[1:0] == 2'b00);
  assign setup   = i_psel & ~i_penable;
  assign access  = i_psel & i_penable & o_pready;
  assign wr_ok   = access & i_pwrite & aligned & is_mapped(idx);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function is_mapped;
    input [5:0] a;
    begin
      case (a)
        `CWFF_IDX_WAKE_CFG,
        `CWFF_IDX_EXT_MASK,
        `CWFF_IDX_STD_MASK,
        `CWFF_IDX_DATA_1_3,
        `CWFF_IDX_DATA_4_6,
        `CWFF_IDX_DATA_7_8,
        `CWFF_IDX_EXT_REF,
        `CWFF_IDX_IRQ_STAT,
        `CWFF_IDX_IRQ_MASK: is_mapped = 1'b1;
        default:            is_mapped = 1'b0;
      endcase
    end
  endfunction

  // current content of a register word; reserved bits stay zero
  function [23:0] reg_word;
    input [5:0] a;
    begin
      case (a)
        `CWFF_IDX_WAKE_CFG: begin
          reg_word = `CWFF_RST_WORD;
          reg_word[`CWFF_CFG_IDE_BIT] = long_format_select;
          reg_word[`CWFF_CFG_DLC_MSB:`CWFF_CFG_DLC_LSB] =
            match_byte_count;
          reg_word[`CWFF_CFG_ID_MSB:`CWFF_CFG_ID_LSB] =
            reference_identifier;
        end
        `CWFF_IDX_EXT_MASK:
          reg_word = {6'h00, extension_ignore_bits};
        `CWFF_IDX_STD_MASK:
          reg_word = {13'h0000, base_ignore_bits};
        `CWFF_IDX_DATA_1_3:
          reg_word = {ref_byte_three, ref_byte_two, ref_byte_one};
        `CWFF_IDX_DATA_4_6:
          reg_word = {ref_byte_six, ref_byte_five, ref_byte_four};
        `CWFF_IDX_DATA_7_8:
          reg_word = {8'h00, ref_byte_eight, ref_byte_seven};
        `CWFF_IDX_EXT_REF:
          reg_word = {6'h00, reference_extension};
        `CWFF_IDX_IRQ_STAT:
          reg_word = {22'h000000, irq_status};
        `CWFF_IDX_IRQ_MASK:
          reg_word = {22'h000000, irq_mask};
        default:
          reg_word = `CWFF_RST_WORD;
      endcase
    end
  endfunction

  // byte-lane merge of write data into the old word
  function [23:0] lane_merge;
    input [23:0] old;
    input [31:0] d;
    input [3:0]  s;
    integer      b;
    begin
      lane_merge = old;
      for (b = 0; b < 3; b = b + 1) begin
        if (s[b]) begin
          lane_merge[8*b +: 8] = d[8*b +: 8];
        end
      end
    end
  endfunction

  assign next_word = lane_merge(reg_word(idx), i_pwdata, i_pstrb);

  // ----------------------------------------------------------------
  // write strobes, one per register word
  // ----------------------------------------------------------------
  wire        we_cfg;
  wire        we_ext_mask;
  wire        we_std_mask;
  wire        we_data_1_3;
  wire        we_data_4_6;
  wire        we_data_7_8;
  wire        we_ext_ref;
  wire        we_irq_stat;
  wire        we_irq_mask;

  assign we_cfg      = wr_ok & (idx == `CWFF_IDX_WAKE_CFG);
  assign we_ext_mask = wr_ok & (idx == `CWFF_IDX_EXT_MASK);
  assign we_std_mask = wr_ok & (idx == `CWFF_IDX_STD_MASK);
  assign we_data_1_3 = wr_ok & (idx == `CWFF_IDX_DATA_1_3);
  assign we_data_4_6 = wr_ok & (idx == `CWFF_IDX_DATA_4_6);
  assign we_data_7_8 = wr_ok & (idx == `CWFF_IDX_DATA_7_8);
  assign we_ext_ref  = wr_ok & (idx == `CWFF_IDX_EXT_REF);
  assign we_irq_stat = wr_ok & (idx == `CWFF_IDX_IRQ_STAT);
  assign we_irq_mask = wr_ok & (idx == `CWFF_IDX_IRQ_MASK);

  // a mask write reaches the line in the same cycle as a status change
  assign next_mask   = we_irq_mask ? next_word[1:0] : irq_mask;

  // ----------------------------------------------------------------
  // apb answer: no wait state, ready and data both registered
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= setup;
      o_pslverr <= setup & ~(aligned & is_mapped(idx));
    end
  end

  // read data is zero outside a read access so a stale word never shows
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_prdata <= 32'h00000000;
    end else if (setup & ~i_pwrite) begin
      o_prdata <= {8'h00, reg_word(idx)};
    end else begin
      o_prdata <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // writable registers, one process per register word
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      long_format_select   <= 1'b0;
      match_byte_count     <= `CWFF_RST_DLC;
      reference_identifier <= `CWFF_RST_STD_MASK;
    end else if (we_cfg) begin
      long_format_select   <= next_word[`CWFF_CFG_IDE_BIT];
      match_byte_count     <=
        next_word[`CWFF_CFG_DLC_MSB:`CWFF_CFG_DLC_LSB];
      reference_identifier <=
        next_word[`CWFF_CFG_ID_MSB:`CWFF_CFG_ID_LSB];
    end
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      extension_ignore_bits <= `CWFF_RST_EXT_MASK;
    end else if (we_ext_mask) begin
      extension_ignore_bits <= next_word[17:0];
    end
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      base_ignore_bits <= `CWFF_RST_STD_MASK;
    end else if (we_std_mask) begin
      base_ignore_bits <= next_word[10:0];
    end
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      ref_byte_one   <= `CWFF_RST_BYTE;
      ref_byte_two   <= `CWFF_RST_BYTE;
      ref_byte_three <= `CWFF_RST_BYTE;
    end else if (we_data_1_3) begin
      ref_byte_one   <= next_word[7:0];
      ref_byte_two   <= next_word[15:8];
      ref_byte_three <= next_word[23:16];
    end
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      ref_byte_four <= `CWFF_RST_BYTE;
      ref_byte_five <= `CWFF_RST_BYTE;
      ref_byte_six  <= `CWFF_RST_BYTE;
    end else if (we_data_4_6) begin
      ref_byte_four <= next_word[7:0];
      ref_byte_five <= next_word[15:8];
      ref_byte_six  <= next_word[23:16];
    end
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      ref_byte_seven <= `CWFF_RST_BYTE;
      ref_byte_eight <= `CWFF_RST_BYTE;
    end else if (we_data_7_8) begin
      ref_byte_seven <= next_word[7:0];
      ref_byte_eight <= next_word[15:8];
    end
  end

  // the extension reference sits in a word of its own
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      reference_extension <= `CWFF_RST_EXT_MASK;
    end else if (we_ext_ref) begin
      reference_extension <= next_word[17:0];
    end
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      irq_mask <= `CWFF_RST_IRQ;
    end else begin
      irq_mask <= next_mask;
    end
  end

  // ----------------------------------------------------------------
  // frame compare
  // ----------------------------------------------------------------
  assign ref_bytes = {ref_byte_eight, ref_byte_seven,
                      ref_byte_six,   ref_byte_five,
                      ref_byte_four,  ref_byte_three,
                      ref_byte_two,   ref_byte_one};

  cwff_match u_match (
    .i_long_format_select    (long_format_select),
    .i_reference_identifier  (reference_identifier),
    .i_reference_extension   (reference_extension),
    .i_base_ignore_bits      (base_ignore_bits),
    .i_extension_ignore_bits (extension_ignore_bits),
    .i_match_byte_count      (match_byte_count),
    .i_ref_bytes             (ref_bytes),
    .i_frame_ide             (i_frame_ide),
    .i_frame_id              (i_frame_id),
    .i_frame_dlc             (i_frame_dlc),
    .i_frame_data            (i_frame_data),
    .o_hit                   (hit)
  );

  // ----------------------------------------------------------------
  // events and interrupt
  // ----------------------------------------------------------------
  assign set_evt[`CWFF_ST_WAKE] = i_frame_valid & hit;
  assign set_evt[`CWFF_ST_MISS] = i_frame_valid & ~hit;

  // write-one-to-clear; a clear only reaches lane 0
  assign clr_evt = (we_irq_stat & i_pstrb[0]) ? i_pwdata[1:0] : 2'b00;

  // a new event in the clear cycle survives the clear
  genvar e;
  generate
    for (e = 0; e < 2; e = e + 1) begin : g_evt
      assign next_status[e] = set_evt[e] | (irq_status[e] & ~clr_evt[e]);
    end
  endgenerate

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      irq_status <= `CWFF_RST_IRQ;
    end else begin
      irq_status <= next_status;
    end
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_wake_frame_event <= 1'b0;
      o_irq              <= 1'b0;
    end else begin
      o_wake_frame_event <= set_evt[`CWFF_ST_WAKE];
      // built from next values so the line tracks status without lag
      o_irq              <= |(next_status & next_mask);
    end
  end

endmodule

// ==== tb/cwff_frame_src.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// bus node model: hands received frames to the filter
// ----------------------------------------------------------------
module cwff_frame_src (
  // clock
  input  wire         i_clk,
  // frame towards the filter
  output logic        o_valid,
  output logic        o_ide,
  output logic [28:0] o_id,
  output logic [3:0]  o_dlc,
  output logic [63:0] o_data
);
  initial begin
    o_valid = 1'b0;
    o_ide = 1'b0;
    o_id = 29'h0;
    o_dlc = 4'h0;
    o_data = 64'h0;
  end

  task automatic send(input logic ide, input logic [28:0] id,
                      input logic [3:0] dlc, input logic [63:0] data);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_ide <= ide;
    o_id <= id;
    o_dlc <= dlc;
    o_data <= data;
    @(posedge i_clk);
    o_valid <= 1'b0;
    // fields are stale after the pulse: invert so nothing leans on them
    o_ide <= ~ide;
    o_id <= ~id;
    o_dlc <= ~dlc;
    o_data <= ~data;
  endtask
endmodule

// ==== tb/cwff_top_asserts.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// bus and event checks
// ----------------------------------------------------------------
module cwff_top_asserts (
  input wire        i_clk,
  input wire        i_sys_rst,
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [7:0]  i_paddr,
  input wire        i_frame_valid,
  input wire [31:0] o_prdata,
  input wire        o_pready,
  input wire        o_pslverr,
  input wire        o_wake_frame_event,
  input wire        o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  wire rd_acc = o_pready && !i_pwrite;

  a_ready_setup: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  a_ready_single: assert property (o_pready |=> !o_pready)
    else $error("ready held too long");
  a_err_align: assert property (i_psel && !i_penable &&
    i_paddr[1:0] != 2'b00 |=> o_pslverr && o_pready)
    else $error("misaligned access not refused");
  a_idle_rdata: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside access");
  a_top_byte: assert property (o_pready |-> o_prdata[31:24] == 8'h00)
    else $error("read data top byte set");
  // byte addresses 0x64, 0x68, 0x74 are indices 0x19, 0x1a, 0x1d
  a_ext_rsvd: assert property (rd_acc && i_paddr == 8'h64 |->
    o_prdata[23:18] == 6'h00) else $error("ext mask reserved set");
  a_std_rsvd: assert property (rd_acc && i_paddr == 8'h68 |->
    o_prdata[23:11] == 13'h0) else $error("base mask reserved set");
  a_bytes78_rsvd: assert property (rd_acc && i_paddr == 8'h74 |->
    o_prdata[23:16] == 8'h00) else $error("byte 7-8 reserved set");
  a_event_cause: assert property (o_wake_frame_event |-> $past(i_frame_valid))
    else $error("wake event without frame");
  a_reset_clear: assert property ($fell(i_sys_rst) |->
    !o_irq && !o_wake_frame_event && !o_pready) else $error("reset not clean");
endmodule

bind cwff_top cwff_top_asserts u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_frame_valid(i_frame_valid), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_wake_frame_event(o_wake_frame_event), .o_irq(o_irq));

// ==== tb/tb.sv ====
`timescale 1ns/10ps
`include "cwff_regs.vh"
module tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        i_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        i_psel = 1'b0;
  logic        i_penable = 1'b0;
  logic        i_pwrite = 1'b0;
  logic [7:0]  i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  logic [3:0]  i_pstrb = 4'hf;
  wire  [31:0] o_prdata;
  wire         o_pready, o_pslverr, o_wake_frame_event, o_irq, fv, fide;
  wire  [28:0] fid;
  wire  [3:0]  fdlc;
  wire  [63:0] fdata;
  int          mismatches = 0;
  int          n_checks = 0;
  logic [31:0] rd;
  logic        err;
  typedef struct {logic [5:0] idx; logic [23:0] wd, ex;} cwff_reg_row_t;
  typedef struct {logic [23:0] cfg; logic ide; logic [28:0] id;
    logic [3:0] dlc; logic [63:0] data; logic hit;} cwff_frm_row_t;
  cwff_reg_row_t regs[5] = '{'{`CWFF_IDX_EXT_MASK, 24'hffffff, 24'h03ffff},
    '{`CWFF_IDX_STD_MASK, 24'hffffff, 24'h0007ff},
    '{`CWFF_IDX_DATA_1_3, 24'ha1b2c3, 24'ha1b2c3},
    '{`CWFF_IDX_DATA_4_6, 24'h445566, 24'h445566},
    '{`CWFF_IDX_DATA_7_8, 24'hffffff, 24'h00ffff}};
  cwff_frm_row_t frms[11] = '{
    '{24'h008123, 1'b0, {11'h123, 18'h00000}, 4'h8,
      64'hffff445566a1b2c3, 1'b1},
    '{24'h008123, 1'b0, {11'h123, 18'h00000}, 4'h8,
      64'h7fff445566a1b2c3, 1'b0},
    '{24'h002123, 1'b0, {11'h122, 18'h3ffff}, 4'h2, 64'hffb2c3, 1'b1},
    '{24'h002123, 1'b0, {11'h133, 18'h00000}, 4'h2, 64'h00b2c3, 1'b0},
    '{24'h002123, 1'b0, {11'h123, 18'h00000}, 4'h3, 64'h00b2c3, 1'b0},
    '{24'h002123, 1'b0, {11'h123, 18'h00000}, 4'h2, 64'h0000c3, 1'b0},
    '{24'h002123, 1'b1, {11'h123, 18'h2aaaa}, 4'h2, 64'h00b2c3, 1'b0},
    '{24'h402123, 1'b1, {11'h122, 18'h2aaab}, 4'h2, 64'h00b2c3, 1'b1},
    '{24'h402123, 1'b1, {11'h123, 18'h2aaa8}, 4'h2, 64'h00b2c3, 1'b0},
    '{24'h402123, 1'b0, {11'h123, 18'h2aaaa}, 4'h2, 64'h00b2c3, 1'b0},
    '{24'h400123, 1'b1, {11'h123, 18'h2aaaa}, 4'h0, 64'hffffff, 1'b1}};

  always #5 i_clk = ~i_clk;

  cwff_frame_src src (.i_clk(i_clk), .o_valid(fv), .o_ide(fide), .o_id(fid),
    .o_dlc(fdlc), .o_data(fdata));
  cwff_top DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_frame_valid(fv),
    .i_frame_ide(fide), .i_frame_id(fid), .i_frame_dlc(fdlc),
    .i_frame_data(fdata), .o_wake_frame_event(o_wake_frame_event),
    .o_irq(o_irq));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, ex);
    n_checks++;
    if (seen !== ex) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h seen %h", nm, ex, seen);
    end
  endtask

  task automatic complete_run;
    if (mismatches == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    i_pstrb <= s;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (o_pready !== 1'b1) begin
      mismatches++;
      complete_run();
    end else begin
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [5:0] i, input logic [23:0] d);
    // top byte set on purpose: it must be ignored
    apb(1'b1, {i, 2'b00}, {8'hff, d}, 4'hf);
  endtask

  task automatic rdx(input logic [5:0] i, input logic [23:0] ex);
    apb(1'b0, {i, 2'b00}, 32'h0, 4'hf);
    chk("read", rd, {8'h00, ex});
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    foreach (regs[k]) rdx(regs[k].idx, 24'h0);
    foreach (regs[k]) begin
      wr(regs[k].idx, regs[k].wd);
      rdx(regs[k].idx, regs[k].ex);
    end
    wr(`CWFF_IDX_STD_MASK, 24'h000001);
    wr(`CWFF_IDX_EXT_MASK, 24'h000001);
    wr(`CWFF_IDX_EXT_REF, 24'h02aaaa);
    wr(`CWFF_IDX_IRQ_MASK, 24'h000001);
    foreach (frms[k]) begin
      wr(`CWFF_IDX_WAKE_CFG, frms[k].cfg);
      src.send(frms[k].ide, frms[k].id, frms[k].dlc, frms[k].data);
      @(negedge i_clk);
      chk("wake", {31'h0, o_wake_frame_event},
          {31'h0, frms[k].hit});
    end
    chk("irq", {31'h0, o_irq}, 32'h1);
    rdx(`CWFF_IDX_IRQ_STAT, 24'h000003);
    wr(`CWFF_IDX_IRQ_MASK, 24'h000000);
    @(negedge i_clk);
    chk("irq masked", {31'h0, o_irq}, 32'h0);
    wr(`CWFF_IDX_IRQ_STAT, 24'h000001);
    rdx(`CWFF_IDX_IRQ_STAT, 24'h000002);
    apb(1'b0, 8'hfc, 32'h0, 4'hf);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    apb(1'b1, 8'h69, 32'h0, 4'hf);
    chk("misaligned", {31'h0, err}, 32'h1);
    rdx(`CWFF_IDX_DATA_1_3, 24'ha1b2c3);
    apb(1'b1, {`CWFF_IDX_DATA_1_3, 2'b00}, 32'h0, 4'h2);
    rdx(`CWFF_IDX_DATA_1_3, 24'ha100c3);
    // mid-run reset with the miss interrupt raised
    wr(`CWFF_IDX_IRQ_MASK, 24'h000002);
    @(negedge i_clk);
    chk("irq miss", {31'h0, o_irq}, 32'h1);
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(negedge i_clk);
    chk("irq after reset", {31'h0, o_irq}, 32'h0);
    foreach (regs[k]) rdx(regs[k].idx, 24'h0);
    rdx(`CWFF_IDX_WAKE_CFG, 24'h000000);
    rdx(`CWFF_IDX_IRQ_STAT, 24'h000000);
    complete_run();
  end
endmodule
